// >>> diag_pkg.sv
package diag_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] ERR_WORD_ADDR = 8'hA3;
    localparam int FLAG_COUNT = 13;
    // ==========================================================
    // field positions in the error word
    localparam int BIT_REF = 0;
    localparam int BIT_CLAMP = 1;
    localparam int BIT_THERM = 2;
    localparam int BIT_OVF = 3;
    localparam int BIT_SELF = 4;
    localparam int BIT_RADIUS = 5;
    localparam int BIT_PWRUP = 6;
    localparam int BIT_EE_CORR = 7;
    localparam int BIT_LOW_SUP = 8;
    localparam int BIT_HIGH_SUP = 9;
    localparam int BIT_EE_UNCORR = 10;
    localparam int BIT_SHADOW = 11;
    localparam int BIT_OSC = 12;
    // critical flags: cleared only by reset or by their mask bit
    localparam logic [12:0] CRITICAL_MASK = 13'h1_C00;
    localparam logic [12:0] FLAGS_RESET = 13'h0_040;
    // ==========================================================
    // timing
    localparam int PERIODIC_UPDATES = 10;
    localparam int CLAMP_FILT_MAX = 16;
    localparam int OVF_FILT_MAX = 16;
    localparam int RADIUS_FILT_MAX = 8;
    localparam int RADIUS_DIV = 128;
    localparam int OSC_TOL_PCT = 20;
    // oscillator check window in main clock cycles
    localparam int OSC_WINDOW = 256;
endpackage

// >>> hold_filter.sv
`timescale 1ns/1ns
// ==========================================================
// fault hold-off: condition must persist for N updates
module hold_filter
    import diag_pkg::*;
#(
    parameter int MAX_CNT = 16
)
(
    input wire logic clk_in, // clock
    input wire logic rst_in, // sync reset
    input wire logic upd_in, // angle update pulse
    input wire logic cond_in, // raw condition
    input wire logic [4:0] filt_in, // required periods
    output logic fault_out // filtered fault
);
    logic [4:0] cnt_q;
    logic [4:0] lim;

    // clip the setting to this filter's maximum
    assign lim = (filt_in > 5'(MAX_CNT)) ? 5'(MAX_CNT) : filt_in;

    // count consecutive updates with the condition
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cnt_q <= 5'h0_0;
        end
        else if (upd_in)
        begin
            if (!cond_in)
                cnt_q <= 5'h0_0;
            else if (cnt_q < lim)
                cnt_q <= cnt_q + 5'h0_1;
        end
    end

    assign fault_out = cond_in && (cnt_q >= lim);
endmodule // hold_filter

// >>> diag_flags.sv
`timescale 1ns/1ns
// How it works
// - read-only 13-bit error word at 0xA3
// - non-critical flags clear on read or report
// - reference check flag, maskable
// - clamp hit per update, hold-off up to 16, mask
// - thermal saturation flag, maskable
// - overflow is OR of three sources, frontend one unmasked
// - correction overflow built from trims and gated window/saturations
// - overflow per update, hold-off up to 16
// - oscillator compare every 10 updates, 20%
// - oscillator mismatch clears only at reset or when masked
// - self-test flag checked every 10 updates
// - radius squared from floored axes, strict window
// - radius enables, mask, hold-off up to 8
// - radius squared readable
// - powerup flag clears on read or report after first update
// - first frame carries powerup flag in sent or pwm mode
// - margin test never drives diagnostic state
// - eeprom flags set only during eeprom read
// - shadow parity every 10 updates, critical
module diag_flags
    import diag_pkg::*;
(
    input wire logic clk_in, // 125 MHz clock
    input wire logic rst_in, // power-on reset, sync high
    input wire logic upd_in, // angle update pulse
    input wire logic [7:0] rd_addr_in, // serial read address
    input wire logic rd_in, // serial read strobe
    output logic [31:0] rd_data_out, // read data
    input wire logic report_in, // word sent by protocol
    input wire logic ref_bad_in, // reference out of tolerance
    input wire logic clamp_in, // angle at a limit
    input wire logic therm_sat_in, // temp sensor saturated
    input wire logic ovf_lin_in, // linearizer overflow
    input wire logic ovf_fe_in, // frontend overflow
    input wire logic trim_fac_sat_in, // factory trim saturation
    input wire logic trim_cus_sat_in, // customer trim saturation
    input wire logic ofs_out_win_in, // pre-gain offset outside window
    input wire logic gain_sat_in, // saturation after gain
    input wire logic post_ofs_sat_in, // saturation after post offset
    input wire logic selftest_bad_in, // test vector mismatch
    input wire logic angle_late_in, // output watchdog missed
    input wire logic [15:0] first_axis_value, // first axis sample
    input wire logic [15:0] second_axis_value, // second axis sample
    input wire logic [15:0] thr_min_in, // radius floor threshold
    input wire logic [15:0] thr_max_in, // radius ceiling threshold
    input wire logic thr_min_en_in, // floor compare enable
    input wire logic thr_max_en_in, // ceiling compare enable
    input wire logic ee_reading_in, // eeprom read in progress
    input wire logic ee_single_in, // corrected ecc error
    input wire logic ee_multi_in, // uncorrectable ecc error
    input wire logic margin_fail_in, // margin test result
    input wire logic parity_bad_in, // shadow parity mismatch
    input wire logic low_sup_in, // undervoltage
    input wire logic high_sup_in, // overvoltage
    input wire logic wdog_osc_in, // watchdog oscillator level
    input wire logic [12:0] mask_in, // per-flag masks
    input wire logic sat_lin_mask_in, // linearizer mask
    input wire logic sat_cor_mask_in, // correction mask
    input wire logic ofs_win_en_in, // offset window check enable
    input wire logic gain_sat_en_in, // gain saturation enable
    input wire logic post_sat_en_in, // post offset sat enable
    input wire logic [4:0] fault_filt_in, // hold-off periods
    input wire logic out_digital_in, // sent or pwm mode
    output logic [31:0] radius_squared, // radius squared
    output logic [12:0] flags_out, // live error word
    output logic first_frame_pwrup_out, // first frame flag
    output logic margin_fail_out // margin result, no diag
);
    logic [12:0] flags_q;
    logic [12:0] cond;
    logic [12:0] set_ev;
    logic [12:0] clr_ok;
    logic rd_hit;
    logic clr_ev;
    logic first_upd_q;
    logic first_sent_q;
    logic [3:0] per_cnt_q;
    logic per_tick;
    logic [9:0] osc_main_q;
    logic [9:0] osc_wd_q;
    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;
    logic osc_run_q;
    logic osc_bad_q;
    logic cor_ovf;
    logic ovf_raw;
    logic clamp_f;
    logic ovf_f;
    logic rad_f;
    logic [8:0] a_fl;
    logic [8:0] b_fl;
    logic [17:0] rad_sq;
    logic [31:0] min_sq;
    logic [31:0] max_sq;
    logic rad_bad;

    // ==========================================================
    // read decode and clear events
    assign rd_hit = rd_in && (rd_addr_in == ERR_WORD_ADDR);
    assign clr_ev = rd_hit || report_in;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            rd_data_out <= 32'h0000_0000;
        else if (rd_hit)
            rd_data_out <= {19'h0_0000, flags_q};
        else if (rd_in)
            rd_data_out <= 32'h0000_0000;
    end

    // ==========================================================
    // periodic tick every 10 updates
    assign per_tick = upd_in && (per_cnt_q == 4'(PERIODIC_UPDATES - 1));

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            per_cnt_q <= 4'h0;
        else if (per_tick)
            per_cnt_q <= 4'h0;
        else if (upd_in)
            per_cnt_q <= per_cnt_q + 4'h1;
    end

    // ==========================================================
    // oscillator compare: count both over a window
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end
        else
        begin
            osc_s1_q <= wdog_osc_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    // reference count is a quarter of the window length at nominal ratio
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            osc_run_q <= 1'b0;
            osc_main_q <= 10'h000;
            osc_wd_q <= 10'h000;
            osc_bad_q <= 1'b0;
        end
        else if (per_tick)
        begin
            osc_run_q <= 1'b1;
            osc_main_q <= 10'h000;
            osc_wd_q <= 10'h000;
        end
        else if (osc_run_q)
        begin
            osc_main_q <= osc_main_q + 10'h001;
            if (osc_s2_q && !osc_s3_q)
                osc_wd_q <= osc_wd_q + 10'h001;
            if (osc_main_q == 10'(OSC_WINDOW - 1))
            begin
                osc_run_q <= 1'b0;
                osc_bad_q <= (32'(osc_wd_q) * 32'h0000_0064 >
                    32'(OSC_WINDOW / 4) * 32'(100 + OSC_TOL_PCT)) ||
                    (32'(osc_wd_q) * 32'h0000_0064 <
                    32'(OSC_WINDOW / 4) * 32'(100 - OSC_TOL_PCT));
            end
        end
    end

    // ==========================================================
    // radius squared and window
    assign a_fl = 9'(signed'(first_axis_value) >>> 7);
    assign b_fl = 9'(signed'(second_axis_value) >>> 7);
    assign rad_sq = 18'($signed(a_fl) * $signed(a_fl)) +
        18'($signed(b_fl) * $signed(b_fl));
    assign min_sq = 32'(thr_min_in) * 32'(thr_min_in);
    assign max_sq = 32'(thr_max_in) * 32'(thr_max_in);
    assign rad_bad = (thr_min_en_in && !(32'(rad_sq) > min_sq)) ||
        (thr_max_en_in && !(32'(rad_sq) < max_sq));
    assign radius_squared = 32'(rad_sq);

    // ==========================================================
    // overflow sources
    assign cor_ovf = trim_fac_sat_in || trim_cus_sat_in ||
        (ofs_win_en_in && ofs_out_win_in) ||
        (gain_sat_en_in && gain_sat_in) ||
        (post_sat_en_in && post_ofs_sat_in);
    assign ovf_raw = (ovf_lin_in && !sat_lin_mask_in) || ovf_fe_in ||
        (cor_ovf && !sat_cor_mask_in);

    // hold-off filters
    hold_filter #(.MAX_CNT(CLAMP_FILT_MAX)) u_clamp_filt (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .upd_in(upd_in),
        .cond_in(clamp_in),
        .filt_in(fault_filt_in),
        .fault_out(clamp_f)
    );
    hold_filter #(.MAX_CNT(OVF_FILT_MAX)) u_ovf_filt (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .upd_in(upd_in),
        .cond_in(ovf_raw),
        .filt_in(fault_filt_in),
        .fault_out(ovf_f)
    );
    hold_filter #(.MAX_CNT(RADIUS_FILT_MAX)) u_rad_filt (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .upd_in(upd_in),
        .cond_in(rad_bad),
        .filt_in(fault_filt_in),
        .fault_out(rad_f)
    );

    // ==========================================================
    // live conditions and set events
    always_comb
    begin
        cond = 13'h0_000;
        cond[BIT_REF] = ref_bad_in;
        cond[BIT_CLAMP] = clamp_f;
        cond[BIT_THERM] = therm_sat_in;
        cond[BIT_OVF] = ovf_f;
        cond[BIT_SELF] = selftest_bad_in || angle_late_in;
        cond[BIT_RADIUS] = rad_f;
        cond[BIT_PWRUP] = !first_upd_q;
        cond[BIT_EE_CORR] = ee_reading_in && ee_single_in;
        cond[BIT_LOW_SUP] = low_sup_in;
        cond[BIT_HIGH_SUP] = high_sup_in;
        cond[BIT_EE_UNCORR] = ee_reading_in && ee_multi_in;
        cond[BIT_SHADOW] = parity_bad_in;
        cond[BIT_OSC] = osc_bad_q;
    end

    // sampling cadence per flag
    always_comb
    begin
        set_ev = cond;
        set_ev[BIT_CLAMP] = cond[BIT_CLAMP] && upd_in;
        set_ev[BIT_OVF] = cond[BIT_OVF] && upd_in;
        set_ev[BIT_RADIUS] = cond[BIT_RADIUS] && upd_in;
        set_ev[BIT_SELF] = cond[BIT_SELF] && per_tick;
        set_ev[BIT_SHADOW] = cond[BIT_SHADOW] && per_tick;
        set_ev[BIT_PWRUP] = 1'b0;
        set_ev = set_ev & ~mask_in;
    end

    // clear allowed only when not critical and condition gone
    assign clr_ok = {13{clr_ev}} & ~CRITICAL_MASK & ~cond;

    // ==========================================================
    // flag storage, set wins over clear
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            flags_q <= FLAGS_RESET & 13'h1_FFF;
        else
            flags_q <= ((flags_q & ~clr_ok) | set_ev) & ~mask_in;
    end

    // first angle update seen
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            first_upd_q <= 1'b0;
        else if (upd_in)
            first_upd_q <= 1'b1;
    end

    // in sent or pwm mode, first frame reports powerup unless masked
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            first_sent_q <= 1'b0;
        else if (report_in)
            first_sent_q <= 1'b1;
    end

    assign first_frame_pwrup_out = out_digital_in && !first_sent_q &&
        !mask_in[BIT_PWRUP];
    assign flags_out = flags_q;
    assign margin_fail_out = margin_fail_in;

    // ==========================================================
    // checks
    AST_CRIT_STICKY: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (flags_q[BIT_OSC] && !mask_in[BIT_OSC]) |=> flags_q[BIT_OSC])
        else $error("oscillator flag dropped");
    AST_READ_WORD: assert property (
        @(posedge clk_in) disable iff (rst_in)
        rd_hit |=> rd_data_out[31:13] == 19'h0_0000)
        else $error("upper error bits not zero");
    AST_MASKED: assert property (
        @(posedge clk_in) disable iff (rst_in)
        mask_in[BIT_REF] |=> !flags_q[BIT_REF])
        else $error("masked reference flag set");
    AST_PERSIST: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (clr_ev && ref_bad_in && !mask_in[BIT_REF]) |=> flags_q[BIT_REF])
        else $error("persisting flag cleared");
    AST_CLEAR: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (clr_ev && !ref_bad_in) |=> !flags_q[BIT_REF])
        else $error("flag not cleared by read");
    AST_PWRUP_HOLD: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (!first_upd_q && flags_q[BIT_PWRUP] && !mask_in[BIT_PWRUP])
        |=> flags_q[BIT_PWRUP])
        else $error("powerup cleared before first update");
    AST_PERIOD: assert property (
        @(posedge clk_in) disable iff (rst_in)
        per_tick |-> per_cnt_q == 4'h9)
        else $error("periodic check off count");
    AST_RADIUS: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (thr_max_en_in && 32'(rad_sq) == max_sq) |-> rad_bad)
        else $error("radius ceiling not strict");
endmodule // diag_flags

// >>> diag_host.sv
`timescale 1ns/1ns
// ==========================================
// programmer side of the serial read path
module diag_host
(
    input wire logic clk_in, // clock
    input wire logic [31:0] rd_data_in, // word returned
    output logic rd_out, // read strobe
    output logic [7:0] rd_addr_out, // read address
    output logic report_out // protocol frame sent
);
    // idle levels at start
    initial
    begin
        rd_out = 1'b0;
        rd_addr_out = 8'h00;
        report_out = 1'b0;
    end
    // one read: strobe for one edge, word ready after it
    task automatic read(input logic [7:0] addr, output logic [31:0] data);
        @(posedge clk_in);
        rd_out <= 1'b1;
        rd_addr_out <= addr;
        @(posedge clk_in);
        rd_out <= 1'b0;
        rd_addr_out <= ~addr; // no stale address left behind
        #1;
        data = rd_data_in;
    endtask
    // one protocol frame carrying the word
    task automatic report;
        @(posedge clk_in);
        report_out <= 1'b1;
        @(posedge clk_in);
        report_out <= 1'b0;
    endtask
endmodule // diag_host

// >>> diag_flag_register_tb.sv
`timescale 1ns/1ns
// ==========================================
// bench for the diagnostic flag word
module diag_flag_register_tb;
    import diag_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic upd = 1'b0;
    logic [18:0] c = '0;
    logic [7:0] e = 8'h83;
    logic [12:0] m = '0;
    logic [4:0] filt = 5'h01;
    logic [15:0] ax = '0, bx = '0, tmin = 16'h0001, tmax = '0;
    logic wd = 1'b0;
    int wd_half = 2;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    logic rd, rpt, ffp, mfo;
    logic [7:0] ra;
    logic [31:0] rdat, rsq, d;
    logic [12:0] fl;
    int ci[4] = '{0, 2, 17, 18};
    int bi[4] = '{BIT_REF, BIT_THERM, BIT_LOW_SUP, BIT_HIGH_SUP};
    int oc[11] = '{3, 3, 4, 5, 5, 6, 7, 7, 8, 8, 9};
    logic [7:0] oe[11] = '{8'h03, 8'h02, 8'h03, 8'h03, 8'h01, 8'h01,
        8'h01, 8'h05, 8'h01, 8'h09, 8'h11};
    logic ov[11] = '{0, 1, 1, 0, 1, 1, 0, 1, 0, 1, 1};
    logic [15:0] ra_x[3] = '{16'h0180, 16'hFF7F, 16'h007F};
    logic [15:0] ra_y[3] = '{16'h0200, 16'h0000, 16'hFFFF};
    logic [31:0] ra_e[3] = '{32'h0000_0019, 32'h0000_0004, 32'h0000_0001};
    logic [7:0] we[5] = '{8'h20, 8'h20, 8'h40, 8'h40, 8'h00};
    logic [15:0] wn[5] = '{16'h0005, 16'h0004, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] wx[5] = '{16'h0000, 16'h0000, 16'h0005, 16'h0006, 16'h0005};
    logic wv[5] = '{1, 0, 1, 0, 0};
    // clock, watchdog oscillator, run limit
    always #4 clk_in = ~clk_in;
    always
    begin
        repeat (wd_half) @(posedge clk_in);
        wd <= ~wd;
    end
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    diag_flags DUT (.clk_in(clk_in), .rst_in(rst_in), .upd_in(upd),
        .rd_addr_in(ra), .rd_in(rd), .rd_data_out(rdat), .report_in(rpt),
        .ref_bad_in(c[0]), .clamp_in(c[1]), .therm_sat_in(c[2]),
        .ovf_lin_in(c[3]), .ovf_fe_in(c[4]), .trim_fac_sat_in(c[5]),
        .trim_cus_sat_in(c[6]), .ofs_out_win_in(c[7]), .gain_sat_in(c[8]),
        .post_ofs_sat_in(c[9]), .selftest_bad_in(c[10]),
        .angle_late_in(c[11]), .ee_reading_in(c[12]), .ee_single_in(c[13]),
        .ee_multi_in(c[14]), .margin_fail_in(c[15]), .parity_bad_in(c[16]),
        .low_sup_in(c[17]), .high_sup_in(c[18]), .first_axis_value(ax),
        .second_axis_value(bx), .thr_min_in(tmin), .thr_max_in(tmax),
        .thr_min_en_in(e[5]), .thr_max_en_in(e[6]), .wdog_osc_in(wd),
        .mask_in(m), .sat_lin_mask_in(e[0]), .sat_cor_mask_in(e[1]),
        .ofs_win_en_in(e[2]), .gain_sat_en_in(e[3]), .post_sat_en_in(e[4]),
        .fault_filt_in(filt), .out_digital_in(e[7]), .radius_squared(rsq),
        .flags_out(fl), .first_frame_pwrup_out(ffp),
        .margin_fail_out(mfo));
    diag_host host (.clk_in(clk_in), .rd_data_in(rdat), .rd_out(rd),
        .rd_addr_out(ra), .report_out(rpt));
    // ==========================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic fb(input string nm, input int b, input logic v);
        chk(nm, 32'(fl[b]), 32'(v));
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic upd_n(input int n);
        repeat (n)
        begin
            @(posedge clk_in);
            upd <= 1'b1;
            @(posedge clk_in);
            upd <= 1'b0;
        end
        tick(1);
    endtask
    // drop all conditions, then clear by a read
    task automatic quiet;
        @(posedge clk_in);
        c <= '0;
        m <= '0;
        e <= 8'h03;
        filt <= 5'h01;
        host.read(ERR_WORD_ADDR, d);
        tick(1);
    endtask
    task automatic hold(input int k, input int lim, input int b);
        @(posedge clk_in);
        filt <= 5'h14;
        case (k)
            0: c[1] <= 1'b1;
            1: c[4] <= 1'b1;
            default: e[5] <= 1'b1;
        endcase
        // lim updates are held off, the next one reports
        upd_n(lim);
        fb("early", b, 1'b0);
        upd_n(1);
        fb("held", b, 1'b1);
        quiet();
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        tick(1);
        chk("flags", 32'(fl), 32'h0000_0040);
        chk("first frame", 32'(ffp), 32'h0000_0001);
        host.read(ERR_WORD_ADDR, d);
        chk("word", d, 32'h0000_0040);
        tick(1);
        chk("pwrup kept", 32'(fl), 32'h0000_0040);
        host.read(8'hA4, d);
        chk("unmapped", d, 32'h0000_0000);
        upd_n(1);
        host.report();
        tick(1);
        chk("report clear", 32'(fl), 32'h0000_0000);
        chk("frame sent", 32'(ffp), 32'h0000_0000);
        foreach (ci[i])
        begin
            @(posedge clk_in);
            c[ci[i]] <= 1'b1;
            upd_n(1);
            fb("set", bi[i], 1'b1);
            host.read(ERR_WORD_ADDR, d);
            tick(1);
            fb("persist", bi[i], 1'b1);
            quiet();
            fb("cleared", bi[i], 1'b0);
            @(posedge clk_in);
            m[bi[i]] <= 1'b1;
            c[ci[i]] <= 1'b1;
            upd_n(1);
            fb("masked", bi[i], 1'b0);
            quiet();
        end
        hold(0, CLAMP_FILT_MAX, BIT_CLAMP);
        hold(1, OVF_FILT_MAX, BIT_OVF);
        hold(2, RADIUS_FILT_MAX, BIT_RADIUS);
        foreach (oc[i])
        begin
            @(posedge clk_in);
            c[oc[i]] <= 1'b1;
            e <= oe[i];
            upd_n(2);
            fb("ovf src", BIT_OVF, ov[i]);
            quiet();
        end
        @(posedge clk_in);
        c[4] <= 1'b1;
        m[BIT_OVF] <= 1'b1;
        upd_n(2);
        fb("ovf mask", BIT_OVF, 1'b0);
        quiet();
        foreach (ra_x[i])
        begin
            @(posedge clk_in);
            ax <= ra_x[i];
            bx <= ra_y[i];
            tick(1);
            chk("radius", rsq, ra_e[i]);
        end
        @(posedge clk_in);
        ax <= 16'h0180;
        bx <= 16'h0200;
        foreach (we[i])
        begin
            @(posedge clk_in);
            e <= we[i] | 8'h03;
            tmin <= wn[i];
            tmax <= wx[i];
            upd_n(2);
            fb("window", BIT_RADIUS, wv[i]);
            quiet();
        end
        for (int k = 10; k <= 11; k++)
        begin
            @(posedge clk_in);
            c[k] <= 1'b1;
            upd_n(PERIODIC_UPDATES);
            fb("selftest", BIT_SELF, 1'b1);
            quiet();
            fb("selftest clr", BIT_SELF, 1'b0);
        end
        @(posedge clk_in);
        c[13] <= 1'b1;
        upd_n(1);
        fb("ee idle", BIT_EE_CORR, 1'b0);
        @(posedge clk_in);
        c[12] <= 1'b1;
        tick(2);
        fb("ee corr", BIT_EE_CORR, 1'b1);
        quiet();
        fb("ee corr clr", BIT_EE_CORR, 1'b0);
        @(posedge clk_in);
        c[12] <= 1'b1;
        c[14] <= 1'b1;
        c[16] <= 1'b1;
        upd_n(PERIODIC_UPDATES);
        quiet();
        fb("ee uncorr", BIT_EE_UNCORR, 1'b1);
        fb("shadow", BIT_SHADOW, 1'b1);
        upd_n(PERIODIC_UPDATES);
        tick(OSC_WINDOW + 40);
        fb("osc nominal", BIT_OSC, 1'b0);
        wd_half = 4;
        upd_n(PERIODIC_UPDATES);
        tick(OSC_WINDOW + 40);
        quiet();
        fb("osc slow", BIT_OSC, 1'b1);
        host.report();
        tick(1);
        fb("osc report", BIT_OSC, 1'b1);
        @(posedge clk_in);
        c[15] <= 1'b1;
        tick(2);
        chk("margin", 32'(mfo), 32'h0000_0001);
        chk("no diag", 32'(fl & ~CRITICAL_MASK), 32'h0000_0000);
        @(posedge clk_in);
        c <= '0;
        m[BIT_PWRUP] <= 1'b1;
        e[7] <= 1'b1;
        rst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        tick(1);
        chk("reset all", 32'(fl), 32'h0000_0000);
        chk("frame masked", 32'(ffp), 32'h0000_0000);
        give_verdict();
    end
endmodule // diag_flag_register_tb
